// ==== hdl/bfc_pkg.sv ====
// shared constants and coding functions of the 64b/66b framer
`default_nettype none
package bfc_pkg;
  // ----------------------------------------
  // block and multiblock geometry
  // ----------------------------------------
  localparam int PAY_W = 64;
  localparam int HDR_W = 2;
  localparam int BLK_W = PAY_W + HDR_W;
  localparam int MB_BLOCKS = 32;
  localparam int EMB_MB = 1;
  localparam int LOCAL_GROUP_BOUNDARY_CLOCK_BITS = BLK_W * MB_BLOCKS * EMB_MB;
  localparam int IDX_W = $clog2(MB_BLOCKS);
  localparam int BUF_DEPTH = 2;
  // ----------------------------------------
  // header-bit stream layout
  // ----------------------------------------
  localparam int SW_W = MB_BLOCKS;
  localparam int CRC_W = 12;
  localparam int FEC_W = 26;
  localparam int CRC_GRP = 3;
  localparam int CRC_GRPS = 4;
  localparam int FEC_HI = 22;
  localparam int FEC_MID = 23;
  localparam int FEC_LO = 24;
  localparam int GROUP_END_FLAG_POS = 22;
  localparam int MULTIBLOCK_END_PATTERN_LSB = 27;
  localparam logic [4:0] MULTIBLOCK_END_PATTERN_PAT = 5'h10;
  localparam logic [SW_W-1:0] ONES_CRC = 32'h80A8_8888;
  localparam logic [SW_W-1:0] ONES_FEC = 32'h8000_0000;
  // polynomials without the top term; crc one is 0x987 in short form
  localparam logic [FEC_W-1:0] CRC_POLY = 26'h000_030F;
  localparam logic [FEC_W-1:0] FEC_POLY = 26'h022_0211;
  // ----------------------------------------
  // self-synchronous scrambler x^58 + x^39 + 1
  // ----------------------------------------
  localparam int SCR_W = 58;
  localparam int SCR_TAP_A = 57;
  localparam int SCR_TAP_B = 38;

  // payload bit i sits at link position i + 2, bit 0 goes first
  function automatic logic [SCR_W+PAY_W-1:0] scramble(input logic [SCR_W-1:0] st, input logic [PAY_W-1:0] d,
                                                      input logic desc);
    logic [SCR_W-1:0] s;
    logic [PAY_W-1:0] q;
    logic b;
    s = st;
    q = '0;
    for (int i = 0; i < PAY_W; i++) begin
      b = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      q[i] = b;
      s = {s[SCR_W-2:0], desc ? d[i] : b};
    end
    return {s, q};
  endfunction

  // serial parity over one block, transmission order
  function automatic logic [FEC_W-1:0] parStep(input logic [FEC_W-1:0] c, input logic [PAY_W-1:0] d,
                                              input logic fec);
    logic [FEC_W-1:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < PAY_W; i++) begin
      fb = d[i] ^ (fec ? r[FEC_W-1] : r[CRC_W-1]);
      r = {r[FEC_W-2:0], 1'b0} ^ (fb ? (fec ? FEC_POLY : CRC_POLY) : '0);
      if (!fec) r[FEC_W-1:CRC_W] = '0;
    end
    return r;
  endfunction

  // parity word to stream word, fixed ones, pilots and zero commands
  function automatic logic [SW_W-1:0] streamWord(input logic [FEC_W-1:0] p, input logic fec);
    logic [SW_W-1:0] w;
    w = fec ? ONES_FEC : ONES_CRC;
    w[GROUP_END_FLAG_POS] = 1'b1;
    if (fec) begin
      for (int k = 0; k < FEC_HI; k++) w[k] = p[FEC_W-1-k];
      w[FEC_MID] = p[CRC_GRP];
      for (int k = 0; k < CRC_GRP; k++) w[FEC_LO+k] = p[CRC_GRP-1-k];
    end else begin
      for (int g = 0; g < CRC_GRPS; g++)
        for (int k = 0; k < CRC_GRP; k++) w[(CRC_GRP+1)*g+k] = p[CRC_W-1-CRC_GRP*g-k];
    end
    return w;
  endfunction

  // stream word back to parity word
  function automatic logic [FEC_W-1:0] streamPar(input logic [SW_W-1:0] w, input logic fec);
    logic [FEC_W-1:0] p;
    p = '0;
    if (fec) begin
      for (int k = 0; k < FEC_HI; k++) p[FEC_W-1-k] = w[k];
      p[CRC_GRP] = w[FEC_MID];
      for (int k = 0; k < CRC_GRP; k++) p[CRC_GRP-1-k] = w[FEC_LO+k];
    end else begin
      for (int g = 0; g < CRC_GRPS; g++)
        for (int k = 0; k < CRC_GRP; k++) p[CRC_W-1-CRC_GRP*g-k] = w[(CRC_GRP+1)*g+k];
    end
    return p;
  endfunction
endpackage
`default_nettype wire

// ==== hdl/bfc_link_if.sv ====
// block link between framer and receiver
`timescale 1ns/1ps
`default_nettype none
interface bfc_link_if;
  import bfc_pkg::*;
  logic linkValid;
  logic linkReady;
  logic [BLK_W-1:0] linkData;
  modport tx (output linkValid, output linkData, input linkReady);
  modport rx (input linkValid, input linkData, output linkReady);
endinterface
`default_nettype wire

// ==== hdl/bfc_tx.sv ====
// transmit framer: scramble, header, header-bit stream, parity, boundary clock
`timescale 1ns/1ps
`default_nettype none
module bfc_tx
  import bfc_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user block input
  input wire logic inValid,
  output logic inReady,
  input wire logic [PAY_W-1:0] inData,
  // system pins
  input wire logic sysref,
  input wire logic fecMode,
  // link
  bfc_link_if.tx link,
  // status
  output logic lemcPulse
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  function automatic logic [PW-1:0] ptrNext(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sysMeta_r;
  logic sysSync_r;
  logic sysPrev_r;
  logic fecMeta_r;
  logic fecSync_r;
  logic sysRise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysMeta_r <= 1'b0;
      sysSync_r <= 1'b0;
      sysPrev_r <= 1'b0;
      fecMeta_r <= 1'b0;
      fecSync_r <= 1'b0;
    end else begin
      sysMeta_r <= sysref;
      sysSync_r <= sysMeta_r;
      sysPrev_r <= sysSync_r;
      fecMeta_r <= fecMode;
      fecSync_r <= fecMeta_r;
    end
  end

  assign sysRise = sysSync_r & ~sysPrev_r;

  // ----------------------------------------
  // two-entry input buffer
  // ----------------------------------------
  logic [PAY_W-1:0] buf_r [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] cnt_r;
  logic bufValid;
  logic push;
  logic pop;
  logic stageFree;
  logic linkValid_r;
  logic [BLK_W-1:0] linkData_r;

  assign inReady = (cnt_r != (PW + 1)'(DEPTH));
  assign bufValid = (cnt_r != '0);
  assign push = inValid & inReady;
  assign stageFree = ~linkValid_r | link.linkReady;
  assign pop = bufValid & stageFree;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wrPtr_r <= ptrNext(wrPtr_r);
      if (pop) rdPtr_r <= ptrNext(rdPtr_r);
      if (push & ~pop) cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) buf_r[wrPtr_r] <= inData;
  end

  // ----------------------------------------
  // scrambler and block assembly
  // ----------------------------------------
  logic [SCR_W-1:0] scrSt_r;
  logic [SCR_W+PAY_W-1:0] scrOut;
  logic [PAY_W-1:0] scrPay;
  logic [IDX_W-1:0] idx_r;
  logic fecCur_r;
  logic fecNow;
  logic [FEC_W-1:0] parRun_r;
  logic [FEC_W-1:0] parHold_r;
  logic [FEC_W-1:0] parNext;
  logic [SW_W-1:0] sw;
  logic swBit;
  logic lastBlk;
  logic local_group_boundary_clock_r;

  assign scrOut = scramble(scrSt_r, buf_r[rdPtr_r], 1'b0);
  assign scrPay = scrOut[PAY_W-1:0];
  assign fecNow = (idx_r == '0) ? fecSync_r : fecCur_r;
  assign lastBlk = (idx_r == IDX_W'(MB_BLOCKS - 1));
  assign sw = streamWord(parHold_r, fecNow);
  assign swBit = sw[idx_r];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scrSt_r <= '0;
    end else if (pop) begin
      scrSt_r <= scrOut[SCR_W+PAY_W-1:PAY_W];
    end
  end

  // ----------------------------------------
  // link output stage
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkValid_r <= 1'b0;
      linkData_r <= '0;
    end else if (pop) begin
      linkValid_r <= 1'b1;
      // header 01 sends a one, 10 a zero, never equal bits
      linkData_r <= {scrPay, swBit, ~swBit};
    end else if (link.linkReady) begin
      linkValid_r <= 1'b0;
    end
  end

  assign link.linkValid = linkValid_r;
  assign link.linkData = linkData_r;

  // ----------------------------------------
  // multiblock counter and boundary clock
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= '0;
    end else if (sysRise) begin
      idx_r <= '0;
    end else if (pop) begin
      idx_r <= idx_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      local_group_boundary_clock_r <= 1'b0;
    end else begin
      local_group_boundary_clock_r <= pop & lastBlk & ~sysRise;
    end
  end

  assign lemcPulse = local_group_boundary_clock_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fecCur_r <= 1'b0;
    end else if (pop && idx_r == '0) begin
      fecCur_r <= fecSync_r;
    end
  end

  // ----------------------------------------
  // parity generator
  // ----------------------------------------
  assign parNext = parStep((idx_r == '0) ? '0 : parRun_r, scrPay, fecNow);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parRun_r <= '0;
    end else if (sysRise) begin
      parRun_r <= '0;
    end else if (pop) begin
      parRun_r <= parNext;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parHold_r <= '0;
    end else if (sysRise) begin
      parHold_r <= '0;
    end else if (pop & lastBlk) begin
      parHold_r <= parNext;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/bfc_rx.sv ====
// receiving end: header check, stream word, parity compare, descramble
`timescale 1ns/1ps
`default_nettype none
module bfc_rx
  import bfc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  bfc_link_if.rx link,
  // system pins
  input wire logic sysref,
  input wire logic fecMode,
  // user block output
  output logic outValid,
  input wire logic outReady,
  output logic [PAY_W-1:0] outData,
  // status pulses
  output logic hdrErr,
  output logic pilotErr,
  output logic parErr,
  output logic lemcPulse
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sysMeta_r;
  logic sysSync_r;
  logic sysPrev_r;
  logic fecMeta_r;
  logic fecSync_r;
  logic sysRise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysMeta_r <= 1'b0;
      sysSync_r <= 1'b0;
      sysPrev_r <= 1'b0;
      fecMeta_r <= 1'b0;
      fecSync_r <= 1'b0;
    end else begin
      sysMeta_r <= sysref;
      sysSync_r <= sysMeta_r;
      sysPrev_r <= sysSync_r;
      fecMeta_r <= fecMode;
      fecSync_r <= fecMeta_r;
    end
  end

  assign sysRise = sysSync_r & ~sysPrev_r;

  // ----------------------------------------
  // block intake
  // ----------------------------------------
  logic outValid_r;
  logic [PAY_W-1:0] outData_r;
  logic take;
  logic [PAY_W-1:0] pay;
  logic [SCR_W+PAY_W-1:0] dsc;
  logic [SCR_W-1:0] scrSt_r;
  logic [IDX_W-1:0] idx_r;
  logic [SW_W-1:0] sw_r;
  logic [SW_W-1:0] swFull;
  logic [FEC_W-1:0] parRun_r;
  logic [FEC_W-1:0] parHold_r;
  logic [FEC_W-1:0] parNext;
  logic [SW_W-1:0] ones;
  logic haveMb_r;
  logic lastBlk;

  assign link.linkReady = ~outValid_r | outReady;
  assign take = link.linkValid & link.linkReady;
  assign pay = link.linkData[BLK_W-1:HDR_W];
  assign dsc = scramble(scrSt_r, pay, 1'b1);
  assign lastBlk = (idx_r == IDX_W'(MB_BLOCKS - 1));
  assign swFull = {link.linkData[1], sw_r[SW_W-2:0]};
  assign parNext = parStep((idx_r == '0) ? '0 : parRun_r, pay, fecSync_r);
  assign ones = fecSync_r ? ONES_FEC : ONES_CRC;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid_r <= 1'b0;
      outData_r <= '0;
      scrSt_r <= '0;
    end else if (take) begin
      outValid_r <= 1'b1;
      outData_r <= dsc[PAY_W-1:0];
      scrSt_r <= dsc[SCR_W+PAY_W-1:PAY_W];
    end else if (outReady) begin
      outValid_r <= 1'b0;
    end
  end

  assign outValid = outValid_r;
  assign outData = outData_r;

  // ----------------------------------------
  // boundary count, stream word, parity
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= '0;
      sw_r <= '0;
      parRun_r <= '0;
      parHold_r <= '0;
      haveMb_r <= 1'b0;
    end else if (sysRise) begin
      idx_r <= '0;
      parRun_r <= '0;
      haveMb_r <= 1'b0;
    end else if (take) begin
      idx_r <= idx_r + 1'b1;
      sw_r[idx_r] <= link.linkData[1];
      parRun_r <= parNext;
      if (lastBlk) begin
        parHold_r <= parNext;
        haveMb_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // error and boundary pulses
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdrErr <= 1'b0;
      pilotErr <= 1'b0;
      parErr <= 1'b0;
      lemcPulse <= 1'b0;
    end else begin
      hdrErr <= take & (link.linkData[0] == link.linkData[1]);
      pilotErr <= take & lastBlk & ~sysRise & ((swFull[SW_W-1:MULTIBLOCK_END_PATTERN_LSB] != MULTIBLOCK_END_PATTERN_PAT)
                  | ~swFull[GROUP_END_FLAG_POS] | ((swFull & ones) != ones));
      parErr <= take & lastBlk & ~sysRise & haveMb_r
                & (streamPar(swFull, fecSync_r) != parHold_r);
      lemcPulse <= take & lastBlk & ~sysRise;
    end
  end
endmodule
`default_nettype wire

// ==== dv/bfc_link_checker.sv ====
// link checker for the 64b/66b framer
`timescale 1ns/1ps
`default_nettype none
module bfc_link_checker
  import bfc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link and pins
  input wire logic linkValid,
  input wire logic linkReady,
  input wire logic [BLK_W-1:0] linkData,
  input wire logic sysref,
  input wire logic fecMode
);
  // ----------------------------------------
  // block index and parity tracking
  // ----------------------------------------
  logic xfer;
  logic hb;
  logic modeNow;
  logic expBit;
  logic fec_r;
  logic [4:0] idx_r;
  logic fecBit;
  logic prevFec_r;
  logic [25:0] crc_r;
  logic [25:0] prev_r;
  logic [25:0] crcNxt;
  assign xfer = linkValid && linkReady;
  assign hb = linkData[1];
  assign modeNow = (idx_r == 5'h0) ? fecMode : fec_r;
  // crc-12 in the low bits, fire code over all 26 in fec mode
  always_comb begin
    crcNxt = (idx_r == 5'h0) ? 26'h000_0000 : crc_r;
    for (int i = 0; i < PAY_W; i++) begin
      if (modeNow) crcNxt = {crcNxt[24:0], 1'b0} ^ ((linkData[i+2] ^ crcNxt[25]) ? 26'h022_0211 : 26'h000_0000);
      else crcNxt = {14'h0, crcNxt[10:0], 1'b0} ^ ((linkData[i+2] ^ crcNxt[11]) ? 26'h000_030F : 26'h000_0000);
    end
    expBit = prev_r[11 - (idx_r - (idx_r >> 2))];
    fecBit = prev_r[(idx_r < 5'h16) ? 25 - idx_r : ((idx_r == 5'h17) ? 3 : 26 - idx_r)];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idx_r <= '0;
    else if (sysref) idx_r <= '0;
    else if (xfer) idx_r <= idx_r + 5'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) crc_r <= '0;
    else if (xfer) crc_r <= crcNxt;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prev_r <= '0;
    else if (sysref) prev_r <= '0;
    else if (xfer && idx_r == 5'h1F) prev_r <= crcNxt;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fec_r <= 1'b0;
    else if (xfer && idx_r == 5'h0) fec_r <= fecMode;
  end
  // mode of the multiblock whose parity is being carried
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prevFec_r <= 1'b0;
    else if (xfer && idx_r == 5'h1F) prevFec_r <= modeNow;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_hdr_complement: assert property (linkValid |-> linkData[0] != linkData[1])
    else $error("header bits not complementary");
  a_valid_hold: assert property (linkValid && !linkReady |=> linkValid)
    else $error("block withdrawn before taken");
  a_data_hold: assert property (linkValid && !linkReady |=> $stable(linkData))
    else $error("block changed while stalled");
  a_end_pattern: assert property (xfer && idx_r >= 5'h1B |-> hb == (idx_r == 5'h1F))
    else $error("multiblock end pattern wrong");
  a_group_flag: assert property (xfer && idx_r == 5'h16 |-> hb)
    else $error("group end flag not set");
  a_fixed_ones: assert property (xfer && !modeNow && (idx_r inside {3, 7, 11, 15, 19, 21, 23}) |-> hb)
    else $error("fixed one missing");
  a_cmd_zero: assert property (xfer && !modeNow && (idx_r inside {16, 17, 18, 20, 24, 25, 26}) |-> !hb)
    else $error("command bit not zero");
  a_parity_bit: assert property (xfer && !modeNow && !prevFec_r && idx_r < 5'hF && idx_r[1:0] != 2'h3 |-> hb == expBit)
    else $error("parity bit wrong");
  a_fec_parity: assert property (xfer && modeNow && prevFec_r && idx_r < 5'h1B && idx_r != 5'h16 |-> hb == fecBit)
    else $error("fec parity bit wrong");
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench joining framer and receiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bfc_pkg::*;
  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic inValid = 1'b0;
  logic [PAY_W-1:0] inData = '0;
  logic sysref = 1'b0;
  logic fecMode = 1'b0;
  logic outReady = 1'b1;
  logic inReady, outValid, hdrErr, pilotErr, parErr, txLemc, rxLemc;
  logic [PAY_W-1:0] outData;
  logic [PAY_W-1:0] expQ[$];
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int txCnt = 0;
  int rxCnt = 0;
  int errCnt = 0;
  int parCnt = 0;
  int blkNum = 0;
  bfc_link_if link();
  bfc_tx bfc_tx_i (.clk(clk), .rst_n(rst_n), .inValid(inValid), .inReady(inReady), .inData(inData),
    .sysref(sysref), .fecMode(fecMode), .link(link), .lemcPulse(txLemc));
  bfc_rx bfc_rx_i (.clk(clk), .rst_n(rst_n), .link(link), .sysref(sysref), .fecMode(fecMode),
    .outValid(outValid), .outReady(outReady), .outData(outData), .hdrErr(hdrErr), .pilotErr(pilotErr),
    .parErr(parErr), .lemcPulse(rxLemc));
  bfc_link_checker bfc_link_checker_i (.clk(clk), .rst_n(rst_n), .linkValid(link.linkValid),
    .linkReady(link.linkReady), .linkData(link.linkData), .sysref(sysref), .fecMode(fecMode));
  initial begin
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [PAY_W-1:0] seen, input logic [PAY_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic sendBlocks(input int n);
    int w;
    for (int k = 0; k < n; k++) begin
      inValid = 1'b1;
      inData = {2{32'(blkNum)}} ^ 64'hA5A5_0F0F_5A5A_F0F0;
      w = 0;
      do begin
        @(negedge clk);
        w++;
      end while (inReady !== 1'b1 && w < 200);
      if (w == 200) miscompares++;
      @(posedge clk);
      expQ.push_back(inData);
      blkNum++;
      #2;
    end
    inValid = 1'b0;
  endtask
  task automatic drain();
    int w = 0;
    while (expQ.size() != 0 && w < 500) begin
      @(posedge clk);
      w++;
    end
    idle(3);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // monitors and timeout
  // ----------------------------------------
  always @(negedge clk) begin
    if (rst_n && outValid === 1'b1 && outReady) check(outData, expQ.size() > 0 ? expQ.pop_front() : 'x);
    if (txLemc === 1'b1) txCnt++;
    if (rxLemc === 1'b1) rxCnt++;
    if (hdrErr === 1'b1 || pilotErr === 1'b1) errCnt++;
    if (parErr === 1'b1) parCnt++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int a;
    int b;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    idle(2);
    sendBlocks(96);
    drain();
    check(64'(txCnt), 64'd3);
    check(64'(rxCnt), 64'd3);
    check(64'(errCnt + parCnt), 64'd0);
    $display("test stream done");
    outReady = 1'b0;
    sendBlocks(4);
    idle(5);
    check(64'(inReady), 64'd0);
    outReady = 1'b1;
    sendBlocks(6);
    drain();
    $display("test stall done");
    a = txCnt;
    b = rxCnt;
    sysref = 1'b1;
    idle(2);
    sysref = 1'b0;
    idle(6);
    sendBlocks(31);
    drain();
    check(64'(txCnt - a), 64'd0);
    sendBlocks(1);
    drain();
    check(64'(txCnt - a), 64'd1);
    check(64'(rxCnt - b), 64'd1);
    check(64'(errCnt + parCnt), 64'd0);
    $display("test sysref done");
    a = txCnt;
    b = parCnt;
    sendBlocks(16);
    fecMode = 1'b1;
    sendBlocks(16);
    drain();
    check(64'(parCnt > b), 64'd1);
    sendBlocks(32);
    drain();
    b = parCnt;
    sendBlocks(32);
    drain();
    check(64'(parCnt - b), 64'd0);
    check(64'(errCnt), 64'd0);
    check(64'(txCnt - a), 64'd3);
    $display("test fec done");
    report_and_stop();
  end
endmodule
`default_nettype wire
